// [logic/always_on_wake_config.sv]
// Always-on wake sequencer with its sub-register file
`timescale 1ns/100ps
`default_nettype none
`include "wake_cfg_defs.svh"

module always_on_wake_config
  import wake_cfg_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic [4:0] reg_addr,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [31:0] reg_wdata,
  output logic [31:0] reg_rdata,
  output logic reg_ack,
  input wire logic sleep_enter,
  output logic sleep_ready,
  input wire logic wake_up,
  output logic [`IDX_W-1:0] cfg_snap_idx,
  input wire logic [31:0] cfg_snap_data,
  output logic cfg_load_valid,
  output logic [`IDX_W-1:0] cfg_load_idx,
  output logic [31:0] cfg_load_data,
  output logic cfg_por_load,
  output logic sar_start,
  input wire logic sar_done,
  input wire logic [`MEAS_W-1:0] sar_volt,
  input wire logic [`MEAS_W-1:0] sar_temp,
  output logic [`MEAS_W-1:0] wake_volt,
  output logic [`MEAS_W-1:0] wake_temp,
  output logic wake_volt_valid,
  output logic rx_cal_start,
  input wire logic rx_cal_done,
  output logic pll_idle_req,
  input wire logic pll_locked,
  output logic rx_enable,
  output logic wake_busy
);

  ////////////////////////////////////////////////////////////////////////////
  // Decoding helpers

  function automatic logic hit(input logic [4:0] addr, input logic [4:0] off);
    hit = (addr == off);
  endfunction : hit

  // Next wake stage after the given one, skipping disabled stages
  function automatic wake_state_e next_stage(
    input stage_t done_lvl,
    input logic [`WAKE_W-1:0] cfg
  );
    wake_state_e s;
    s = ST_RUN;
    if (done_lvl < 2'd1 && cfg[`BIT_MEASURE]) begin
      s = ST_MEAS; // R4
    end else if (done_lvl < 2'd2 && cfg[`BIT_RX_CAL]) begin
      s = ST_CAL; // R12
    end else if (done_lvl < 2'd3 &&
                 (cfg[`BIT_PLL_IDLE] || cfg[`BIT_RECEIVE])) begin
      s = ST_PLL; // R10
    end else if (cfg[`BIT_RECEIVE]) begin
      s = ST_RX; // R11
    end
    next_stage = s;
  endfunction : next_stage

  ////////////////////////////////////////////////////////////////////////////
  // Retention array

  retention_if ret ();

  retention_array u_array (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .ret(ret)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Sub-register file

  logic [`WAKE_W-1:0] wake_cfg_reg;
  logic [`WAKE_W-1:0] wake_cfg_next;
  logic [`CMD_W-1:0] cmd_reg;
  logic [`CMD_W-1:0] cmd_next;
  logic [31:0] ret_addr_reg;
  logic [31:0] ret_addr_next;
  logic [31:0] ret_wdata_reg;
  logic [31:0] ret_wdata_next;
  logic [31:0] ret_cfg_reg;
  logic [31:0] ret_cfg_next;
  logic [31:0] rdata_reg;
  logic [31:0] rdata_next;
  logic ack_reg;
  logic ack_next;

  // Sequencer state, declared early for the command clear
  wake_state_e state_reg;
  wake_state_e state_next;
  logic cmd_done_save;
  logic cmd_done_restore;

  always_comb begin
    wake_cfg_next = wake_cfg_reg;
    cmd_next = cmd_reg;
    ret_addr_next = ret_addr_reg;
    ret_wdata_next = ret_wdata_reg;
    ret_cfg_next = ret_cfg_reg;
    rdata_next = rdata_reg;
    ack_next = reg_wr || reg_rd;
    if (reg_wr) begin
      // Reserved bits are stored as written; host keeps them intact
      if (hit(reg_addr, `OFF_WAKE_ACTION)) begin
        wake_cfg_next = reg_wdata[`WAKE_W-1:0]; // R9 R7
      end
      if (hit(reg_addr, `OFF_RET_CMD)) begin
        cmd_next = reg_wdata[`CMD_W-1:0];
      end
      if (hit(reg_addr, `OFF_RET_ADDR)) begin
        ret_addr_next = reg_wdata;
      end
      if (hit(reg_addr, `OFF_RET_WDATA)) begin
        ret_wdata_next = reg_wdata;
      end
      if (hit(reg_addr, `OFF_RET_CFG)) begin
        ret_cfg_next = reg_wdata;
      end
    end
    // Auto clear once executed; a fresh host write in the same cycle wins
    if (cmd_done_save && !(reg_wr && hit(reg_addr, `OFF_RET_CMD))) begin
      cmd_next[`CMD_SAVE] = 1'b0;
    end
    if (cmd_done_restore && !(reg_wr && hit(reg_addr, `OFF_RET_CMD))) begin
      cmd_next[`CMD_RESTORE] = 1'b0;
    end
    if (reg_rd) begin
      rdata_next = 32'h00000000;
      case (reg_addr) // R8
        `OFF_WAKE_ACTION: rdata_next = {8'h00, wake_cfg_reg};
        `OFF_RET_CMD: rdata_next = {24'h000000, cmd_reg};
        `OFF_RET_RDATA: rdata_next = 32'h00000000;
        `OFF_RET_ADDR: rdata_next = ret_addr_reg;
        `OFF_RET_WDATA: rdata_next = ret_wdata_reg;
        `OFF_RET_CFG: rdata_next = ret_cfg_reg;
        default: rdata_next = 32'h00000000;
      endcase
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      wake_cfg_reg <= `WAKE_RST;
      cmd_reg <= `CMD_RST;
      ret_addr_reg <= `WORD_RST;
      ret_wdata_reg <= `WORD_RST;
      ret_cfg_reg <= `WORD_RST;
      rdata_reg <= `WORD_RST;
      ack_reg <= 1'b0;
    end else begin
      wake_cfg_reg <= wake_cfg_next;
      cmd_reg <= cmd_next;
      ret_addr_reg <= ret_addr_next;
      ret_wdata_reg <= ret_wdata_next;
      ret_cfg_reg <= ret_cfg_next;
      rdata_reg <= rdata_next;
      ack_reg <= ack_next;
    end
  end

  assign reg_rdata = rdata_reg;
  assign reg_ack = ack_reg;

  ////////////////////////////////////////////////////////////////////////////
  // Wake sequencer

  logic [`IDX_W-1:0] idx_reg;
  logic [`IDX_W-1:0] idx_next;
  logic from_sleep_reg;
  logic from_sleep_next;
  logic load_valid_reg;
  logic load_valid_next;
  logic [`IDX_W-1:0] load_idx_reg;
  logic [`IDX_W-1:0] load_idx_next;
  logic [31:0] load_data_reg;
  logic [31:0] load_data_next;
  logic ready_reg;
  logic ready_next;
  logic [`MEAS_W-1:0] volt_reg;
  logic [`MEAS_W-1:0] volt_next;
  logic [`MEAS_W-1:0] temp_reg;
  logic [`MEAS_W-1:0] temp_next;
  logic volt_ok_reg;
  logic volt_ok_next;
  logic last_word;

  assign last_word = (idx_reg == `IDX_LAST);

  always_comb begin
    state_next = state_reg;
    idx_next = idx_reg;
    from_sleep_next = from_sleep_reg;
    load_valid_next = 1'b0;
    load_idx_next = load_idx_reg;
    load_data_next = load_data_reg;
    ready_next = 1'b0;
    volt_next = volt_reg;
    temp_next = temp_reg;
    volt_ok_next = volt_ok_reg;
    cmd_done_save = 1'b0;
    cmd_done_restore = 1'b0;
    ret.we = 1'b0;
    ret.idx = idx_reg;
    ret.wdata = cfg_snap_data;
    case (state_reg)
      ST_RUN: begin
        idx_next = `IDX_ZERO;
        // Sleep entry takes priority over pending host commands
        if (sleep_enter) begin
          from_sleep_next = 1'b1;
          state_next = ST_SAVE; // R1
        end else if (cmd_reg[`CMD_SAVE]) begin
          from_sleep_next = 1'b0;
          state_next = ST_SAVE;
        end else if (cmd_reg[`CMD_RESTORE]) begin
          from_sleep_next = 1'b0;
          state_next = ST_LOAD;
        end
      end
      ST_SAVE: begin
        ret.we = 1'b1; // R1
        idx_next = idx_reg + `IDX_ONE;
        if (last_word) begin
          if (from_sleep_reg) begin
            ready_next = 1'b1;
            state_next = ST_SLEEP;
          end else begin
            cmd_done_save = 1'b1;
            state_next = ST_RUN;
          end
        end
      end
      ST_SLEEP: begin
        idx_next = `IDX_ZERO;
        if (wake_up) begin
          volt_ok_next = 1'b0;
          if (wake_cfg_reg[`BIT_RESTORE]) begin
            state_next = ST_LOAD; // R2
          end else begin
            state_next = ST_POR; // R3
          end
        end
      end
      ST_LOAD: begin
        load_valid_next = 1'b1; // R2
        load_idx_next = idx_reg;
        load_data_next = ret.rdata;
        idx_next = idx_reg + `IDX_ONE;
        if (last_word) begin
          if (from_sleep_reg) begin
            state_next = next_stage(2'd0, wake_cfg_reg);
          end else begin
            cmd_done_restore = 1'b1;
            state_next = ST_RUN;
          end
        end
      end
      ST_POR: begin
        state_next = next_stage(2'd0, wake_cfg_reg); // R3
      end
      ST_MEAS: begin
        if (sar_done) begin
          volt_next = sar_volt; // R5
          temp_next = sar_temp; // R5
          volt_ok_next = 1'b1; // R6
          state_next = next_stage(2'd1, wake_cfg_reg);
        end
      end
      ST_CAL: begin
        if (rx_cal_done) begin
          state_next = next_stage(2'd2, wake_cfg_reg); // R12
        end
      end
      ST_PLL: begin
        if (pll_locked) begin
          state_next = next_stage(2'd3, wake_cfg_reg); // R10 R11
        end
      end
      ST_RX: begin
        state_next = ST_RUN; // R11
      end
      default: begin
        state_next = ST_RUN;
      end
    endcase
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_reg <= ST_RUN;
      idx_reg <= `IDX_ZERO;
      from_sleep_reg <= 1'b0;
      load_valid_reg <= 1'b0;
      load_idx_reg <= `IDX_ZERO;
      load_data_reg <= `WORD_RST;
      ready_reg <= 1'b0;
      volt_reg <= '0;
      temp_reg <= '0;
      volt_ok_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      idx_reg <= idx_next;
      from_sleep_reg <= from_sleep_next;
      load_valid_reg <= load_valid_next;
      load_idx_reg <= load_idx_next;
      load_data_reg <= load_data_next;
      ready_reg <= ready_next;
      volt_reg <= volt_next;
      temp_reg <= temp_next;
      volt_ok_reg <= volt_ok_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Stage outputs registered from the next state: pulses on entering each stage, PLL request held through its stage

  logic por_reg;
  logic sar_reg;
  logic cal_reg;
  logic pll_reg;
  logic rx_reg;
  logic entering;

  assign entering = (state_next != state_reg);

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      por_reg <= 1'b0;
      sar_reg <= 1'b0;
      cal_reg <= 1'b0;
      pll_reg <= 1'b0;
      rx_reg <= 1'b0;
    end else begin
      por_reg <= entering && (state_next == ST_POR); // R3
      sar_reg <= entering && (state_next == ST_MEAS); // R4
      cal_reg <= entering && (state_next == ST_CAL); // R12
      pll_reg <= (state_next == ST_PLL); // R10
      rx_reg <= entering && (state_next == ST_RX); // R11
    end
  end

  assign cfg_snap_idx = idx_reg;
  assign cfg_load_valid = load_valid_reg;
  assign cfg_load_idx = load_idx_reg;
  assign cfg_load_data = load_data_reg;
  assign cfg_por_load = por_reg;
  assign sleep_ready = ready_reg;
  assign sar_start = sar_reg;
  assign rx_cal_start = cal_reg;
  assign pll_idle_req = pll_reg;
  assign rx_enable = rx_reg;
  assign wake_volt = volt_reg;
  // Temperature is passed on but never flagged valid
  assign wake_temp = temp_reg; // R6
  assign wake_volt_valid = volt_ok_reg; // R6
  assign wake_busy = (state_reg != ST_RUN);

endmodule : always_on_wake_config

`default_nettype wire

// [logic/wake_cfg_defs.svh]
// Offsets, field positions, reset values and sizes of the always-on wake block
// How it works
// [R1] Entering sleep or deep sleep copies every user configuration word into retention.
// [R2] Restore bit set: each user configuration word is reloaded with its pre-sleep value.
// [R3] Restore bit clear: a power-on-default load pulse is given on wake instead.
// [R4] Measure bit set: voltage and temperature conversions start first on wake.
// [R5] Conversions are 8-bit; results are held for the measurement result sub-register (here held only on wake_volt and wake_temp).
// [R6] Only the wake voltage result is flagged valid; temperature is read elsewhere.
// [R7] Host keeps reserved wake action bits unchanged; the block stores them as written.
// [R8] Six sub-registers at 0x00 to 0x14, stepping by four.
// [R9] Wake action register is 24-bit read/write and selects the wake actions.
// [R10] PLL idle bit set: after wake the block requests PLL idle until locked.
// [R11] Receive bit set: PLL idle is reached first, then the receiver is enabled.
// [R12] Calibration bit set: receiver calibration runs on wake, before receive.
`ifndef WAKE_CFG_DEFS_SVH
`define WAKE_CFG_DEFS_SVH

`define OFF_WAKE_ACTION 5'h00
`define OFF_RET_CMD 5'h04
`define OFF_RET_RDATA 5'h08
`define OFF_RET_ADDR 5'h0c
`define OFF_RET_WDATA 5'h10
`define OFF_RET_CFG 5'h14

`define WAKE_W 24
`define CMD_W 8
`define WAKE_RST 24'h010000
`define CMD_RST 8'h00
`define WORD_RST 32'h00000000

`define BIT_RESTORE 0
`define BIT_MEASURE 1
`define BIT_PLL_IDLE 8
`define BIT_RECEIVE 9
`define BIT_RX_CAL 11

`define CMD_RESTORE 0
`define CMD_SAVE 1

`define MEAS_W 8
`define CFG_WORDS 8
`define IDX_W 3
`define IDX_LAST 3'h7
`define IDX_ZERO 3'h0
`define IDX_ONE 3'h1

`endif

// [logic/wake_cfg_pkg.sv]
// Types shared by the always-on wake block
package wake_cfg_pkg;

  typedef enum logic [3:0] {
    ST_RUN,
    ST_SAVE,
    ST_SLEEP,
    ST_LOAD,
    ST_POR,
    ST_MEAS,
    ST_CAL,
    ST_PLL,
    ST_RX
  } wake_state_e;

  typedef logic [1:0] stage_t;

endpackage : wake_cfg_pkg

// [logic/retention_if.sv]
// Port bundle between the sequencer and the retention array
`timescale 1ns/100ps
`default_nettype none
`include "wake_cfg_defs.svh"

interface retention_if;
  logic we;
  logic [`IDX_W-1:0] idx;
  logic [31:0] wdata;
  logic [31:0] rdata;

  modport ctrl (output we, output idx, output wdata, input rdata);
  modport store (input we, input idx, input wdata, output rdata);
endinterface : retention_if

`default_nettype wire

// [logic/retention_array.sv]
// Always-on retention array, flip-flop words addressed by index
`timescale 1ns/100ps
`default_nettype none
`include "wake_cfg_defs.svh"

module retention_array
  import wake_cfg_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst_n,
  retention_if.store ret
);

  logic [31:0] word_reg [`CFG_WORDS];
  logic [31:0] word_next [`CFG_WORDS];

  genvar gi;
  generate
    for (gi = 0; gi < `CFG_WORDS; gi++) begin : g_word
      always_comb begin
        word_next[gi] = word_reg[gi];
        if (ret.we && (ret.idx == `IDX_W'(gi))) begin
          word_next[gi] = ret.wdata;
        end
      end

      always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
          word_reg[gi] <= `WORD_RST;
        end else begin
          word_reg[gi] <= word_next[gi];
        end
      end
    end
  endgenerate

  assign ret.rdata = word_reg[ret.idx];

endmodule : retention_array

`default_nettype wire

// [verification/host_reg_model.sv]
// Host side model: register bus cycles and user config words
`timescale 1ns/100ps
`default_nettype none

module host_reg_model (
  input wire logic core_clk,
  input wire logic reg_ack,
  input wire logic [31:0] reg_rdata,
  input wire logic [2:0] cfg_snap_idx,
  output logic [4:0] reg_addr,
  output logic reg_wr,
  output logic reg_rd,
  output logic [31:0] reg_wdata,
  output logic [31:0] cfg_snap_data
);
  initial begin
    reg_addr = 5'h1f;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_wdata = 32'h0;
  end
  // Index in low bits so swapped words show up
  assign cfg_snap_data = {16'h5a5a, 13'h0, cfg_snap_idx};

  //////////////////////////////
  task automatic access(input logic w, input logic [4:0] a, input logic [31:0] d,
                        output logic [31:0] q, output logic ok);
    @(posedge core_clk);
    reg_addr <= a;
    reg_wr <= w;
    reg_rd <= ~w;
    reg_wdata <= d;
    @(posedge core_clk);
    reg_wr <= 1'b0;
    reg_rd <= 1'b0;
    // Released data does not keep the old word
    reg_wdata <= ~d;
    @(negedge core_clk);
    ok = reg_ack;
    q = reg_rdata;
  endtask : access

  task automatic set_wake(input logic [23:0] act, output logic ok);
    logic [31:0] q;
    access(1'b0, 5'h00, 32'h0, q, ok);
    access(1'b1, 5'h00, {8'h0, (q[23:0] & ~24'h000b03) | act}, q, ok);
  endtask : set_wake
endmodule : host_reg_model

`default_nettype wire

// [verification/always_on_wake_config_assertions.sv]
// Port checks for the always-on wake block
`timescale 1ns/100ps
`default_nettype none
`include "wake_cfg_defs.svh"

module always_on_wake_config_assertions (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic [4:0] reg_addr,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [31:0] reg_wdata,
  input wire logic [31:0] reg_rdata,
  input wire logic reg_ack,
  input wire logic sleep_enter,
  input wire logic sleep_ready,
  input wire logic wake_up,
  input wire logic cfg_load_valid,
  input wire logic cfg_por_load,
  input wire logic sar_done,
  input wire logic [`MEAS_W-1:0] sar_volt,
  input wire logic [`MEAS_W-1:0] wake_volt,
  input wire logic wake_volt_valid,
  input wire logic rx_cal_start,
  input wire logic pll_idle_req,
  input wire logic pll_locked,
  input wire logic rx_enable,
  input wire logic wake_busy
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  logic asleep_reg, asleep_next, restore_reg, restore_next;

  always_comb begin
    asleep_next = (asleep_reg | sleep_ready) & ~wake_up;
    restore_next = restore_reg;
    if (reg_wr && reg_addr == `OFF_WAKE_ACTION) begin
      restore_next = reg_wdata[`BIT_RESTORE];
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      asleep_reg <= 1'b0;
      restore_reg <= 1'b0;
    end else begin
      asleep_reg <= asleep_next;
      restore_reg <= restore_next;
    end
  end

  //////////////////////////////
  a_ack_follows: assert property ((reg_wr || reg_rd) |=> reg_ack)
    else $error("ack missing");
  a_wake_width: assert property (reg_ack && $past(reg_rd) && $past(reg_addr) == 5'h00 |-> reg_rdata[31:24] == 8'h00)
    else $error("wake action wider than 24");
  a_rdata_zero: assert property (reg_ack && $past(reg_rd) && $past(reg_addr) == 5'h08 |-> reg_rdata == 32'h0)
    else $error("read result not zero");
  a_save_time: assert property ((sleep_enter && !wake_busy) |-> ##9 sleep_ready)
    else $error("save time wrong");
  a_restore_burst: assert property ((wake_up && asleep_reg && restore_reg) |-> ##2 cfg_load_valid [*8])
    else $error("restore burst wrong");
  a_por_pulse: assert property ((wake_up && asleep_reg && !restore_reg) |=> cfg_por_load && !cfg_load_valid)
    else $error("default load missing");
  a_volt_latch: assert property ((sar_done && wake_busy) |=> wake_volt_valid && wake_volt == $past(sar_volt))
    else $error("wake voltage not latched");
  a_pll_hold: assert property ((pll_idle_req && !pll_locked) |=> pll_idle_req)
    else $error("pll request dropped");
  a_rx_after_lock: assert property (rx_enable |-> $past(pll_locked))
    else $error("receive before lock");
  a_cal_first: assert property (rx_cal_start |-> !pll_idle_req && !rx_enable)
    else $error("calibration late");

  c_sleep: cover property (sleep_ready);
  c_restore: cover property (cfg_load_valid ##1 !cfg_load_valid);
  c_receive: cover property (rx_enable);
endmodule : always_on_wake_config_assertions

bind always_on_wake_config always_on_wake_config_assertions chk (.core_clk, .rst_n, .reg_addr,
  .reg_wr, .reg_rd, .reg_wdata, .reg_rdata, .reg_ack, .sleep_enter, .sleep_ready, .wake_up,
  .cfg_load_valid, .cfg_por_load, .sar_done, .sar_volt, .wake_volt, .wake_volt_valid,
  .rx_cal_start, .pll_idle_req, .pll_locked, .rx_enable, .wake_busy);

`default_nettype wire

// [verification/always_on_wake_config_tb.sv]
// Self-checking bench for the always-on wake block
`timescale 1ns/100ps
`default_nettype none
`include "wake_cfg_defs.svh"

module always_on_wake_config_tb;
  logic core_clk = 1'b0;
  logic rst_n = 1'b0;
  logic sleep_enter = 1'b0, wake_up = 1'b0, sar_done = 1'b0, rx_cal_done = 1'b0;
  logic pll_locked = 1'b0;
  logic [7:0] sar_volt = 8'h3c, sar_temp = 8'h8e, wake_volt, wake_temp;
  logic [2:0] sd = 3'h0, cd = 3'h0, pl = 3'h0, cfg_snap_idx, cfg_load_idx;
  logic [4:0] reg_addr;
  logic [31:0] reg_wdata, reg_rdata, cfg_snap_data, cfg_load_data;
  logic reg_wr, reg_rd, reg_ack, sleep_ready, cfg_load_valid, cfg_por_load, sar_start;
  logic wake_volt_valid, rx_cal_start, pll_idle_req, rx_enable, wake_busy;
  int error_cnt = 0, checks_done = 0, nl, np, ks, kc, kp, kr;

  always #5 core_clk = ~core_clk;

  always_on_wake_config dut (.core_clk, .rst_n, .reg_addr, .reg_wr, .reg_rd, .reg_wdata,
    .reg_rdata, .reg_ack, .sleep_enter, .sleep_ready, .wake_up, .cfg_snap_idx,
    .cfg_snap_data, .cfg_load_valid, .cfg_load_idx, .cfg_load_data, .cfg_por_load,
    .sar_start, .sar_done, .sar_volt, .sar_temp, .wake_volt, .wake_temp, .wake_volt_valid,
    .rx_cal_start, .rx_cal_done, .pll_idle_req, .pll_locked, .rx_enable, .wake_busy);

  host_reg_model host (.core_clk, .reg_ack, .reg_rdata, .cfg_snap_idx, .reg_addr, .reg_wr,
    .reg_rd, .reg_wdata, .cfg_snap_data);

  // Converter, calibration and PLL stand-ins answer a few cycles late
  always @(posedge core_clk) begin
    sd <= {sd[1:0], sar_start};
    cd <= {cd[1:0], rx_cal_start};
    pl <= {pl[1:0], pll_idle_req};
    sar_done <= sd[1];
    sar_volt <= sd[1] ? 8'hc3 : 8'h3c;
    sar_temp <= sd[1] ? 8'h71 : 8'h8e;
    rx_cal_done <= cd[2];
    pll_locked <= pl[2] & pll_idle_req;
  end

  //////////////////////////////
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    checks_done++;
    if (got !== exp) begin
      error_cnt++;
      $display("FAIL %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  // For reads d is the expected word
  task automatic acc(input logic w, input logic [4:0] a, input logic [31:0] d);
    logic [31:0] q;
    logic ok;
    host.access(w, a, d, q, ok);
    chk("ack", 32'h1, {31'h0, ok});
    if (!w) chk("rdata", d, q);
  endtask : acc

  task automatic sleep_wake(input logic [23:0] act);
    logic ok;
    int k;
    host.set_wake(act, ok);
    k = 0;
    @(posedge core_clk);
    sleep_enter <= 1'b1;
    @(posedge core_clk);
    sleep_enter <= 1'b0;
    do begin
      @(negedge core_clk);
      k++;
    end while (sleep_ready !== 1'b1 && k < 40);
    chk("save cycles", 32'd9, k);
    {nl, np, ks, kc, kp, kr, k} = '0;
    @(posedge core_clk);
    wake_up <= 1'b1;
    @(posedge core_clk);
    wake_up <= 1'b0;
    do begin
      @(negedge core_clk);
      k++;
      if (cfg_load_valid === 1'b1) begin
        chk("load idx", nl, {29'h0, cfg_load_idx});
        chk("load word", {16'h5a5a, 13'h0, 3'(nl)}, cfg_load_data);
        nl++;
      end
      if (cfg_por_load === 1'b1) np++;
      if (sar_start === 1'b1) ks = k;
      if (rx_cal_start === 1'b1) kc = k;
      if (pll_idle_req === 1'b1 && kp == 0) kp = k;
      if (rx_enable === 1'b1) kr = k;
    end while (wake_busy !== 1'b0 && k < 80);
    chk("busy end", 32'h0, {31'h0, wake_busy});
  endtask : sleep_wake

  // Host command: count busy cycles and restored words, then see the bit clear
  task automatic run_cmd(input logic [7:0] c, input int loads);
    int k, nb;
    k = 0;
    nb = 0;
    nl = 0;
    acc(1'b1, 5'h04, {24'h0, c});
    do begin
      @(negedge core_clk);
      k++;
      if (wake_busy === 1'b1) nb++;
      if (cfg_load_valid === 1'b1) begin
        chk("cmd load word", {16'h5a5a, 13'h0, 3'(nl)}, cfg_load_data);
        nl++;
      end
    end while (wake_busy !== 1'b0 && k < 40);
    chk("cmd busy", 32'd8, nb);
    chk("cmd loads", loads, nl);
    acc(1'b0, 5'h04, 32'h0);
  endtask : run_cmd

  task automatic t_commands();
    run_cmd(8'h02, 0);
    run_cmd(8'h01, 8);
    $display("test commands done");
  endtask : t_commands

  //////////////////////////////
  task automatic t_regs();
    acc(1'b0, 5'h00, 32'h00010000);
    for (int i = 1; i < 6; i++) acc(1'b0, 5'(4 * i), 32'h0);
    acc(1'b1, 5'h00, 32'hffffffff);
    acc(1'b0, 5'h00, 32'h00ffffff);
    for (int i = 3; i < 6; i++) acc(1'b1, 5'(4 * i), 32'h1234abc0 + i);
    for (int i = 3; i < 6; i++) acc(1'b0, 5'(4 * i), 32'h1234abc0 + i);
    acc(1'b1, 5'h08, 32'hffffffff);
    acc(1'b0, 5'h08, 32'h0);
    acc(1'b1, 5'h18, 32'hffffffff);
    acc(1'b0, 5'h18, 32'h0);
    acc(1'b1, 5'h00, 32'h00010000);
    $display("test regs done");
  endtask : t_regs

  task automatic t_restore_all();
    sleep_wake(24'h000b03);
    chk("loads", 32'd8, nl);
    chk("por", 32'd0, np);
    chk("measure first", 32'h1, {31'h0, ks != 0 && ks < kc});
    chk("volt", 32'hc3, {24'h0, wake_volt});
    chk("temp", 32'h71, {24'h0, wake_temp});
    chk("volt valid", 32'h1, {31'h0, wake_volt_valid});
    chk("cal first", 32'h1, {31'h0, kc != 0 && kc < kp});
    chk("rx last", 32'h1, {31'h0, kp != 0 && kp < kr});
    $display("test restore_all done");
  endtask : t_restore_all

  task automatic t_defaults_pll();
    sleep_wake(24'h000100);
    chk("por", 32'd1, np);
    chk("loads", 32'd0, nl);
    chk("measure", 32'd0, ks);
    chk("stale volt", 32'h0, {31'h0, wake_volt_valid});
    chk("cal", 32'd0, kc);
    chk("pll", 32'h1, {31'h0, kp != 0});
    chk("rx", 32'd0, kr);
    acc(1'b0, 5'h00, 32'h00010100);
    $display("test defaults_pll done");
  endtask : t_defaults_pll

  task automatic print_verdict();
    $display("checks %0d mismatches %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : print_verdict

  initial begin
    repeat (5) @(posedge core_clk);
    rst_n <= 1'b1;
    t_regs();
    t_commands();
    t_restore_all();
    t_defaults_pll();
    print_verdict();
  end

  // Run needs under two hundred cycles
  initial begin
    repeat (5000) @(posedge core_clk);
    error_cnt++;
    print_verdict();
  end
endmodule : always_on_wake_config_tb

`default_nettype wire
